/* verilog/standby_seq_map.svh */
`ifndef STANDBY_SEQ_MAP_SVH
`define STANDBY_SEQ_MAP_SVH

// ----------------------------------------
// timing figures, port width and reset values
// ----------------------------------------
`define CLK_PERIOD_NS      25
`define INIT_LEAD_CYCLES   10
`define EXIT_LEAD_NS       100
`define EXIT_LEAD_CYCLES   ((`EXIT_LEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PORT_WIDTH         8
`define LATCH_RESET        8'h00
`define DIR_RESET          8'h00

`endif

/* verilog/standby_seq_pkg.sv */
package standby_seq_pkg;
  typedef enum logic [2:0]
  {
    st_run,
    st_init,
    st_hold,
    st_wait_init
  } seq_state_t;
endpackage

/* verilog/port_pin_ctrl.sv */
`timescale 1ns/10ps
`include "standby_seq_map.svh"

module port_pin_ctrl #(
  parameter int WIDTH = `PORT_WIDTH
) (
  input  wire logic [WIDTH-1:0] dir_in,
  input  wire logic [WIDTH-1:0] latch_in,
  input  wire logic [WIDTH-1:0] held_level_in,
  input  wire logic [WIDTH-1:0] periph_en_in,
  input  wire logic [WIDTH-1:0] periph_out_in,
  input  wire logic [WIDTH-1:0] periph_dir_in,
  input  wire logic             hold_in,
  input  wire logic             periph_reset_in,
  output logic      [WIDTH-1:0] pin_o_out,
  output logic      [WIDTH-1:0] pin_oe_n_out,
  output logic      [WIDTH-1:0] pullup_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pin
      logic use_periph;
      logic drive;
      // modules in reset free their pins
      assign use_periph = periph_en_in[i] & ~periph_reset_in;
      assign drive = use_periph ? periph_dir_in[i] : dir_in[i];
      // outputs keep previous level while held
      assign pin_o_out[i] = hold_in ? held_level_in[i]
                          : (use_periph ? periph_out_in[i] : latch_in[i]);
      assign pin_oe_n_out[i] = ~drive;
      // pull-up only for input with latch high
      assign pullup_out[i] = ~drive & ~use_periph & latch_in[i];
    end
  endgenerate
endmodule // port_pin_ctrl

/* verilog/hw_standby_seq.sv */
`timescale 1ns/10ps
`include "standby_seq_map.svh"

// Summary of operation
// - held input pins float; pull-up only when direction 0 and latch 1.
// - held output pins keep driving their previous level.
// - initialized module pins revert to general ports per direction and latch.
// - general port direction from direction bit; modules may take pins over.

module hw_standby_seq
  import standby_seq_pkg::*;
#(
  parameter int WIDTH = `PORT_WIDTH
) (
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic             chip_init_pin_n_in,
  input  wire logic             low_power_hold_pin_n_in,
  input  wire logic [WIDTH-1:0] dir_in,
  input  wire logic [WIDTH-1:0] port_output_latch_bit_in,
  input  wire logic [WIDTH-1:0] periph_en_in,
  input  wire logic [WIDTH-1:0] periph_out_in,
  input  wire logic [WIDTH-1:0] periph_dir_in,
  output logic      [WIDTH-1:0] pin_o_out,
  output logic      [WIDTH-1:0] pin_oe_n_out,
  output logic      [WIDTH-1:0] pullup_out,
  output logic                  standby_out,
  output logic                  core_reset_out,
  output logic                  ram_kept_out
);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  seq_state_t state;
  seq_state_t next_state;
  logic [3:0] init_cnt;
  logic [3:0] next_init_cnt;
  logic       ram_ok;
  logic       next_ram_ok;
  logic [WIDTH-1:0] held;
  logic [WIDTH-1:0] next_held;
  logic [WIDTH-1:0] comb_o;
  logic [WIDTH-1:0] comb_oe_n;
  logic [WIDTH-1:0] comb_pu;
  logic             hold;

  always_comb
  begin
    next_state    = state;
    next_init_cnt = init_cnt;
    next_ram_ok   = ram_ok;
    next_held     = held;
    unique case (state)
      st_run:
      begin
        next_held = comb_o;
        if (!low_power_hold_pin_n_in)
        begin
          next_ram_ok = 1'b0;
          next_state  = st_hold;
        end
        else if (!chip_init_pin_n_in)
        begin
          next_init_cnt = 4'h1;
          next_state    = st_init;
        end
      end
      st_init:
      begin
        // pins drive latch levels here, so hold keeps those
        next_held = comb_o;
        if (init_cnt != 4'hf)
          next_init_cnt = init_cnt + 4'h1;
        // ram kept only after 10 init clocks
        if (!low_power_hold_pin_n_in)
        begin
          next_ram_ok = (init_cnt >= 4'(`INIT_LEAD_CYCLES));
          next_state  = st_hold;
        end
        else if (chip_init_pin_n_in)
          next_state = st_run;
      end
      st_hold:
      begin
        if (low_power_hold_pin_n_in)
          next_state = st_wait_init;
      end
      st_wait_init:
      begin
        // resume through reset on init rise
        if (!low_power_hold_pin_n_in)
          next_state = st_hold;
        else if (chip_init_pin_n_in)
          next_state = st_run;
      end
      default:
        next_state = st_run;
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state    <= st_run;
      init_cnt <= 4'h0;
      ram_ok   <= 1'b1;
      held     <= `LATCH_RESET;
    end
    else
    begin
      state    <= next_state;
      init_cnt <= next_init_cnt;
      ram_ok   <= next_ram_ok;
      held     <= next_held;
    end
  end

  // hold level decided from registered state, avoids pin glitches
  assign hold = (state == st_hold);

  // ----------------------------------------
  // pins
  // ----------------------------------------
  port_pin_ctrl #(.WIDTH(WIDTH)) u_pins (
    .dir_in          (dir_in),
    .latch_in        (port_output_latch_bit_in),
    .held_level_in   (held),
    .periph_en_in    (periph_en_in),
    .periph_out_in   (periph_out_in),
    .periph_dir_in   (periph_dir_in),
    .hold_in         (hold),
    .periph_reset_in (state != st_run),
    .pin_o_out       (comb_o),
    .pin_oe_n_out    (comb_oe_n),
    .pullup_out      (comb_pu)
  );

  // outputs registered; pins lag state by one clock
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_o_out      <= `LATCH_RESET;
      pin_oe_n_out   <= {WIDTH{1'b1}};
      pullup_out     <= '0;
      standby_out    <= 1'b0;
      core_reset_out <= 1'b1;
      ram_kept_out   <= 1'b1;
    end
    else
    begin
      pin_o_out      <= comb_o;
      pin_oe_n_out   <= comb_oe_n;
      pullup_out     <= comb_pu;
      standby_out    <= (next_state == st_hold);
      core_reset_out <= (next_state != st_run);
      ram_kept_out   <= next_ram_ok;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_enter_hold;
    !low_power_hold_pin_n_in && state != st_hold;
  endsequence

  a_hold_entry: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    s_enter_hold |=> standby_out && state == st_hold)
    else $error("standby not entered");
  a_hold_stays: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state == st_hold && !low_power_hold_pin_n_in |=> state == st_hold)
    else $error("standby left early");
  a_resume_reset: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state == st_wait_init && low_power_hold_pin_n_in && chip_init_pin_n_in
    |=> !core_reset_out ##0 state == st_run)
    else $error("resume not via reset");
  a_ram_short: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state == st_init && init_cnt < 4'(`INIT_LEAD_CYCLES) && !low_power_hold_pin_n_in
    |=> !ram_kept_out)
    else $error("ram kept after short init");
  a_ram_long: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state == st_init && init_cnt >= 4'(`INIT_LEAD_CYCLES) && !low_power_hold_pin_n_in
    |=> ram_kept_out)
    else $error("ram lost after long init");
  a_no_init_loss: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state == st_run && !low_power_hold_pin_n_in |=> !ram_kept_out)
    else $error("ram flag kept without init");
  a_held_level: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    hold |=> pin_o_out == $past(held))
    else $error("held level not driven");
  a_pullup_rule: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    pullup_out != '0 |-> (pullup_out & ~pin_oe_n_out) == '0)
    else $error("pull-up on driven pin");
  a_general_dir: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state != st_run |=> pin_oe_n_out == ~$past(dir_in))
    else $error("pins not reverted to port");
endmodule // hw_standby_seq

/* verification/power_supervisor.sv */
`timescale 1ns/10ps
// ----------------------------------------
// supervisor model driving init and standby
// ----------------------------------------
module power_supervisor (
  input  wire logic clock_in,
  output logic      init_n_out,
  output logic      hold_n_out
);
  initial
  begin
    init_n_out = 1'b1;
    hold_n_out = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask
  task automatic enter_keep(input int lead);
    init_n_out = 1'b0;
    step(lead);
    hold_n_out = 1'b0;
    step(2);
    init_n_out = 1'b1;
  endtask
  task automatic enter_plain();
    hold_n_out = 1'b0;
  endtask
  task automatic leave();
    init_n_out = 1'b0;
    step(4);
    hold_n_out = 1'b1;
  endtask
  // split out so the wait state can be seen
  task automatic run_again();
    init_n_out = 1'b1;
  endtask
endmodule // power_supervisor

/* verification/hw_standby_seq_tb.sv */
`timescale 1ns/10ps
module hw_standby_seq_tb;
  import standby_seq_pkg::*;
  logic        clock_in, reset_n_in, init_n, hold_n, low_power_hold_pin_n, crst, kept, keep;
  logic [7:0]  dir, latch, pen, pout, pdir, o, oe_n, pu, ro, rd, hv;
  int          lead;
  logic [26:0] exp_q[$], msk_q[$], e, m;
  int          fail_count = 0;
  int          num_checks = 0;
  hw_standby_seq dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .chip_init_pin_n_in(init_n), .low_power_hold_pin_n_in(hold_n),
    .dir_in(dir), .port_output_latch_bit_in(latch), .periph_en_in(pen),
    .periph_out_in(pout), .periph_dir_in(pdir), .pin_o_out(o), .pin_oe_n_out(oe_n),
    .pullup_out(pu), .standby_out(low_power_hold_pin_n), .core_reset_out(crst), .ram_kept_out(kept));
  power_supervisor sup_u (.clock_in(clock_in), .init_n_out(init_n), .hold_n_out(hold_n));
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask
  task automatic note(input logic [26:0] ev, input logic [26:0] mv);
    exp_q.push_back(ev);
    msk_q.push_back(mv);
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // bounded, a stuck state ends the run
  task automatic wait_low_power_hold_pin_n(input logic v);
    int k;
    for (k = 0; k < 20 && low_power_hold_pin_n !== v; k++)
      tick(1);
    if (low_power_hold_pin_n !== v)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  always @(negedge clock_in)
    if (exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      num_checks++;
      if (({o, oe_n, pu, low_power_hold_pin_n, crst, kept} & m) !== (e & m))
      begin
        fail_count++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, e & m,
                 {o, oe_n, pu, low_power_hold_pin_n, crst, kept} & m);
      end
    end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    reset_n_in = 1'b0;
    {dir, latch, pen, pout, pdir} = '0;
    void'($urandom(20));
    tick(15);
    note({8'h00, 8'hff, 8'h00, 3'b011}, '1);
    tick(1);
    reset_n_in = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      keep = (i % 2 == 0);
      lead = (i == 2) ? 6 : 10;
      {dir, latch, pen, pout, pdir} = 40'({$urandom(), $urandom()});
      tick(3);
      ro = (pen & pout) | (~pen & latch);
      rd = (pen & pdir) | (~pen & dir);
      hv = keep ? latch : ro;
      note({ro, ~rd, 8'h00, 3'b000}, {16'hffff, 8'h00, 3'b110});
      fork
        if (keep) sup_u.enter_keep(lead);
        else sup_u.enter_plain();
        begin
          tick(5);
          if (keep) note({latch, ~dir, 8'h00, 3'b010}, {16'hffff, 8'h00, 3'b110});
        end
      join
      wait_low_power_hold_pin_n(1'b1);
      pout = ~pout;
      latch = ~latch;
      tick(2);
      note({hv, ~dir, ~dir & latch, 2'b11, keep && lead >= 10}, {dir, 8'hff, 8'hff, 3'b111});
      tick(8);
      note({hv, ~dir, 8'h00, 3'b110}, {dir, 8'hff, 8'h00, 3'b110});
      sup_u.leave();
      wait_low_power_hold_pin_n(1'b0);
      tick(3);
      note({24'h0, 3'b010}, {24'h0, 3'b010});
      sup_u.run_again();
      tick(3);
      ro = (pen & pout) | (~pen & latch);
      note({ro, ~rd, 8'h00, 3'b000}, {16'hffff, 8'h00, 3'b110});
    end
    tick(2);
    tally_and_finish();
  end
endmodule // hw_standby_seq_tb
